/* File: design/ddr_sram_pkg.sv */
// Shared constants and carrier types for the two-word burst SRAM pin engine.
package ddr_sram_pkg;

  // Data widths of the two organisations and the byte lane size.
  localparam int DQ_W_X18   = 18;
  localparam int DQ_W_X36   = 36;
  localparam int DQ_W_MAX   = DQ_W_X36;
  localparam int LANE_W     = 9;
  localparam int LANE_N_MAX = DQ_W_MAX / LANE_W;

  // Address widths: 4 M words per array for x18, 2 M words per array for x36.
  localparam int ADDR_W_X18 = 22;
  localparam int ADDR_W_X36 = 21;
  localparam int ADDR_W_MAX = ADDR_W_X18;

  // Every access moves this many words.
  localparam int BURST_LEN  = 2;

  // Write beat buffer depth.
  localparam int FIFO_DEPTH = 8;

  // Read launch pipeline, counted in clock half-edges after the command edge.
  localparam int RD_PIPE_N   = 6;
  localparam int LAT_PLL_B0  = 4;
  localparam int LAT_PLL_B1  = 5;
  localparam int LAT_DDR1_B0 = 1;
  localparam int LAT_DDR1_B1 = 2;

  // One write beat on its way from the pins to the arrays.
  typedef struct packed
  {
    logic [ADDR_W_MAX-1:0] addr;
    logic                  beat;
    logic [LANE_N_MAX-1:0] byte_write_sel_n;
    logic [DQ_W_MAX-1:0]   data;
  } wr_beat_t;

  // One read waiting in the launch pipeline.
  typedef struct packed
  {
    logic                  vld;
    logic [ADDR_W_MAX-1:0] addr;
  } rd_slot_t;

  // All pin inputs, synchronised together so they stay aligned.
  typedef struct packed
  {
    logic                  k;
    logic                  k_n;
    logic                  load_strobe_n;
    logic                  rd_wr;
    logic                  pll_disable_n;
    logic [ADDR_W_MAX-1:0] addr;
    logic [LANE_N_MAX-1:0] byte_write_sel_n;
    logic [DQ_W_MAX-1:0]   dq;
  } pin_bundle_t;

  // Idle pin picture used while in reset: no load, input clocks at their idle levels, PLL enabled.
  localparam pin_bundle_t PIN_RESET = '{k: 1'b0, k_n: 1'b1, load_strobe_n: 1'b1, rd_wr: 1'b1,
                                        pll_disable_n: 1'b1, addr: '0, byte_write_sel_n: '1,
                                        dq: '0};
  localparam rd_slot_t    SLOT_IDLE = '{vld: 1'b0, addr: '0};

endpackage

/* File: design/beat_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides.
module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             i_mclk,
  input  wire logic             i_reset_n,
  // Filling side.
  input  wire logic             i_push_valid,
  output logic                  o_push_ready,
  input  wire logic [WIDTH-1:0] i_push_data,
  // Draining side.
  output logic                  o_pop_valid,
  input  wire logic             i_pop_ready,
  output logic [WIDTH-1:0]      o_pop_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer wrap relies on a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("beat_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0]   count_q;
  wire              push_fire = i_push_valid && o_push_ready;
  wire              pop_fire  = o_pop_valid && i_pop_ready;

  // Full and empty come straight from the occupancy count.
  assign o_push_ready = (count_q != (PTR_W + 1)'(DEPTH));
  assign o_pop_valid  = (count_q != '0);
  assign o_pop_data   = store[rd_ptr_q];

  // Pointers and count; a simultaneous push and pop leaves the count alone.
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push_fire)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop_fire)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_q + (PTR_W + 1)'(push_fire) - (PTR_W + 1)'(pop_fire);
    end
  end

  // Storage needs no reset; only written slots are ever read.
  always_ff @(posedge i_mclk)
  begin
    if (push_fire)
      store[wr_ptr_q] <= i_push_data;
  end

endmodule // beat_fifo

/* File: design/ddr_burst_sram.sv */
// Device-side pin engine of a two-word burst double-data-rate SRAM.
// How it works
// - Each read word is launched on a rising edge of the positive or the negative input clock.
// - Write words are taken from the data bus on rising edges of both input clocks.
// - The data drivers turn off by themselves whenever no read word is being launched.
// - A low load strobe seen at a positive clock rise opens a new bus cycle.
// - Every access moves exactly two words that belong to the one loaded address.
// - A deasserted byte write select keeps that byte of the array unchanged; select 0 is bits 8:0, select 1 bits 17:9.
// - In the wide organisation select 2 governs bits 26:18 and select 3 bits 35:27.
// - Byte write selects are sampled on the same edge as the data word they belong to.
// - One address bus serves reads and writes and is sampled at the positive clock rise of a command.
// - Storage is two arrays of equal depth, one for each word of the burst.
// - With the strobe low, direction high means read and low means write.
// - The output valid flag marks read words and switches on the same edges as the echo clocks.
// - Accesses start only at a positive clock rise, which also captures inputs and launches data.
// - The negative clock rise captures the second write word and launches read words.
// - With the PLL enabled reads return after two and a half cycles, with it disabled after one cycle.
// - A read may start at every positive clock rise and every started read completes.
module ddr_burst_sram
  import ddr_sram_pkg::*;
#(
  parameter int DATA_W = ddr_sram_pkg::DQ_W_X18,
  parameter int ADDR_W = ddr_sram_pkg::ADDR_W_X18
) (
  // System clock and reset.
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset_n,
  // Input clock pair from the controller.
  input  wire logic                  i_k,
  input  wire logic                  i_k_n,
  // Command and address pins.
  input  wire logic                  i_load_strobe_n,
  input  wire logic                  i_rd_wr,
  input  wire logic [ADDR_W-1:0]     i_addr,
  input  wire logic [DATA_W/9-1:0]   i_byte_write_sel_n,
  input  wire logic                  i_pll_disable_n,
  // Shared data bus, split into its three signals.
  input  wire logic [DATA_W-1:0]     i_dq,
  output logic [DATA_W-1:0]          o_dq,
  output logic                       o_dq_oe,
  // Status outputs.
  output logic                       o_output_valid_flag,
  output logic                       o_echo_clock_out,
  output logic                       o_echo_clock_out_n,
  output logic                       o_write_ready
);

  import ddr_sram_pkg::*;

  localparam int LANE_N = DATA_W / LANE_W;
  localparam int DEPTH  = 2 ** ADDR_W;

  // Elaboration checks: the lane logic knows only the two organisations.
  if (!((DATA_W == DQ_W_X18) || (DATA_W == DQ_W_X36)))
  begin : g_bad_width
    $error("ddr_burst_sram serves only 18 or 36 data bits");
  end
  if (ADDR_W < 1 || ADDR_W > ADDR_W_MAX)
  begin : g_bad_addr
    $error("ddr_burst_sram address width out of range");
  end

  // Every pin crosses two flip-flops together, so the bundle stays aligned.
  pin_bundle_t pins_raw;
  pin_bundle_t pins_s1_q;
  pin_bundle_t pins_s2_q;
  logic        k_prev_q;
  logic        k_n_prev_q;

  assign pins_raw = '{k: i_k, k_n: i_k_n, load_strobe_n: i_load_strobe_n, rd_wr: i_rd_wr,
                      pll_disable_n: i_pll_disable_n, addr: ADDR_W_MAX'(i_addr),
                      byte_write_sel_n: LANE_N_MAX'(i_byte_write_sel_n), dq: DQ_W_MAX'(i_dq)};

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pins_s1_q  <= PIN_RESET;
      pins_s2_q  <= PIN_RESET;
      k_prev_q   <= 1'b0;
      k_n_prev_q <= 1'b1;                                    // Idle level, so no false edge after reset.
    end
    else
    begin
      pins_s1_q  <= pins_raw;
      pins_s2_q  <= pins_s1_q;
      k_prev_q   <= pins_s2_q.k;
      k_n_prev_q <= pins_s2_q.k_n;
    end
  end

  // Edge and command decode on the synchronised pins.
  wire k_rise    = pins_s2_q.k && !k_prev_q;
  wire k_n_rise  = pins_s2_q.k_n && !k_n_prev_q;
  wire half_edge = k_rise || k_n_rise;
  wire cmd_load  = k_rise && !pins_s2_q.load_strobe_n;
  wire cmd_read  = cmd_load && pins_s2_q.rd_wr;
  wire cmd_write = cmd_load && !pins_s2_q.rd_wr;
  wire pll_on    = pins_s2_q.pll_disable_n;

  // Write capture: the first word comes at the next positive rise, the second at the negative rise after it.
  logic [ADDR_W-1:0] wr_addr_a_q;
  logic              wr_wait_a_q;
  logic [ADDR_W-1:0] wr_addr_b_q;
  logic              wr_wait_b_q;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_addr_a_q <= '0;
      wr_wait_a_q <= 1'b0;
      wr_addr_b_q <= '0;
      wr_wait_b_q <= 1'b0;
    end
    else if (k_rise)
    begin
      wr_wait_a_q <= cmd_write;
      wr_addr_a_q <= cmd_write ? pins_s2_q.addr[ADDR_W-1:0] : wr_addr_a_q;
      wr_wait_b_q <= wr_wait_a_q;
      wr_addr_b_q <= wr_addr_a_q;
    end
    else if (k_n_rise)
      wr_wait_b_q <= 1'b0;
  end

  // A beat is pushed on the edge that carries it, with its selects from the same edge.
  wire         push_b0 = k_rise && wr_wait_a_q;
  wire         push_b1 = k_n_rise && wr_wait_b_q;
  wire         push_valid = push_b0 || push_b1;
  wr_beat_t    push_beat;
  wire         fifo_push_ready;
  wr_beat_t    pop_beat;
  wire         pop_valid;
  // The array port is lent to the read path on clock edges, so draining stalls there.
  wire         pop_ready = !half_edge;

  assign push_beat = '{addr: ADDR_W_MAX'(push_b0 ? wr_addr_a_q : wr_addr_b_q), beat: push_b1,
                       byte_write_sel_n: pins_s2_q.byte_write_sel_n,
                       data: pins_s2_q.dq} ;

  beat_fifo #(
    .WIDTH ($bits(wr_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_beat_fifo (
    .i_mclk       (i_mclk),
    .i_reset_n    (i_reset_n),
    .i_push_valid (push_valid),
    .o_push_ready (fifo_push_ready),
    .i_push_data  (push_beat),
    .o_pop_valid  (pop_valid),
    .i_pop_ready  (pop_ready),
    .o_pop_data   (pop_beat)
  );

  // Two arrays, one per burst word, both indexed by the loaded address.
  logic [DATA_W-1:0] mem [BURST_LEN][DEPTH];
  wire  [ADDR_W-1:0] pop_addr = pop_beat.addr[ADDR_W-1:0];
  wire  [DATA_W-1:0] pop_old  = mem[pop_beat.beat][pop_addr];
  wire  [DATA_W-1:0] pop_new  = pop_beat.data[DATA_W-1:0];
  logic [DATA_W-1:0] merged;

  // Lane 0 is bits 8:0 and lane 1 bits 17:9; the wide part adds lanes 2 and 3.
  for (genvar l = 0; l < LANE_N; l++)
  begin : g_lane
    assign merged[l*LANE_W +: LANE_W] = pop_beat.byte_write_sel_n[l] ? pop_old[l*LANE_W +: LANE_W]
                                                                     : pop_new[l*LANE_W +: LANE_W];
  end

  // Array write from the buffer; no reset because this is storage.
  always_ff @(posedge i_mclk)
  begin
    if (pop_valid && pop_ready)
      mem[pop_beat.beat][pop_addr] <= merged;
  end

  // Read launch pipeline advances on every half-edge so back-to-back reads never collide.
  rd_slot_t rd_pipe_q [RD_PIPE_N];
  rd_slot_t rd_new;

  assign rd_new = k_rise ? rd_slot_t'{vld: cmd_read, addr: pins_s2_q.addr} : SLOT_IDLE;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rd_pipe_q <= '{default: SLOT_IDLE};
    else if (half_edge)
    begin
      rd_pipe_q[0] <= rd_new;
      for (int s = 1; s < RD_PIPE_N; s++)
        rd_pipe_q[s] <= rd_pipe_q[s-1];
    end
  end

  // Pick the stage that launches on this edge, for the current latency mode.
  wire       b0_stage = pll_on ? rd_pipe_q[LAT_PLL_B0].vld : rd_pipe_q[LAT_DDR1_B0].vld;
  wire       b1_stage = pll_on ? rd_pipe_q[LAT_PLL_B1].vld : rd_pipe_q[LAT_DDR1_B1].vld;
  wire [ADDR_W-1:0] b0_addr = pll_on ? rd_pipe_q[LAT_PLL_B0].addr[ADDR_W-1:0]
                                     : rd_pipe_q[LAT_DDR1_B0].addr[ADDR_W-1:0];
  wire [ADDR_W-1:0] b1_addr = pll_on ? rd_pipe_q[LAT_PLL_B1].addr[ADDR_W-1:0]
                                     : rd_pipe_q[LAT_DDR1_B1].addr[ADDR_W-1:0];
  wire       launch   = half_edge && (b0_stage || b1_stage);
  wire [DATA_W-1:0] launch_word = b0_stage ? mem[0][b0_addr] : mem[1][b1_addr];

  // Output registers; data, enable and valid only change on a clock half-edge.
  logic [DATA_W-1:0] dq_q;
  logic              oe_q;
  logic              valid_q;
  logic              echo_q;
  logic              echo_n_q;
  logic              wr_ready_q;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      dq_q    <= '0;
      oe_q    <= 1'b0;
      valid_q <= 1'b0;
    end
    else if (half_edge)
    begin
      dq_q    <= launch ? launch_word : dq_q;
      oe_q    <= launch;
      valid_q <= launch;
    end
  end

  // Echo clocks follow the synchronised input clocks, so the valid flag moves on their edges.
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      echo_q     <= 1'b0;
      echo_n_q   <= 1'b0;
      wr_ready_q <= 1'b0;
    end
    else
    begin
      echo_q     <= pins_s2_q.k;
      echo_n_q   <= pins_s2_q.k_n;
      wr_ready_q <= fifo_push_ready;
    end
  end

  assign o_dq                = dq_q;
  assign o_dq_oe             = oe_q;
  assign o_output_valid_flag = valid_q;
  assign o_echo_clock_out    = echo_q;
  assign o_echo_clock_out_n  = echo_n_q;
  assign o_write_ready       = wr_ready_q;

  // Helper state for the checks: the last beat pushed into the buffer.
  logic              last_beat_q;
  logic [ADDR_W-1:0] last_addr_q;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      last_beat_q <= 1'b1;
      last_addr_q <= '0;
    end
    else if (push_valid)
    begin
      last_beat_q <= push_b1;
      last_addr_q <= push_beat.addr[ADDR_W-1:0];
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  a_oe_follows_valid: assert property (o_dq_oe == o_output_valid_flag)
    else $error("data drivers on without a read word");

  a_valid_on_edge: assert property ($changed(o_output_valid_flag) |-> $past(half_edge))
    else $error("valid flag moved between clock edges");

  a_idle_edge_quiet: assert property (half_edge && !b0_stage && !b1_stage |=> !o_output_valid_flag)
    else $error("valid flag high in an empty half-cycle");

  a_pll_latency_b0: assert property (half_edge && pll_on && rd_pipe_q[LAT_PLL_B0].vld
                                     |=> o_output_valid_flag && o_dq == $past(mem[0][b0_addr]))
    else $error("first read word missing at the long latency");

  a_ddr1_latency_b1: assert property (half_edge && !pll_on && rd_pipe_q[LAT_DDR1_B1].vld
                                      |=> o_output_valid_flag && o_dq_oe)
    else $error("second read word missing at the short latency");

  a_read_enters_pipe: assert property (cmd_read |=> rd_pipe_q[0].vld
                                       && rd_pipe_q[0].addr == $past(pins_s2_q.addr))
    else $error("read command not loaded with its address");

  a_load_only_on_k: assert property (k_n_rise |=> !rd_pipe_q[0].vld)
    else $error("read started off the positive clock edge");

  a_burst_pairs: assert property (push_b1 |-> !last_beat_q && last_addr_q == wr_addr_b_q)
    else $error("second write word without its first");

  a_write_second_beat: assert property (k_rise && wr_wait_a_q ##1 (!k_rise) [*1] |->
                                        wr_wait_b_q)
    else $error("second write word lost");

  a_byte_kept: assert property (pop_valid && pop_ready && pop_beat.byte_write_sel_n[0]
                                |=> mem[$past(pop_beat.beat)][$past(pop_addr)][LANE_W-1:0]
                                    == $past(pop_old[LANE_W-1:0]))
    else $error("deselected byte was overwritten");

  // Stored and launched words checked against the arrays, plus buffer, write arming and output timing checks.
  a_byte_written: assert property (pop_valid && pop_ready && !pop_beat.byte_write_sel_n[0]
                                   |=> mem[$past(pop_beat.beat)][$past(pop_addr)][LANE_W-1:0]
                                       == $past(pop_new[LANE_W-1:0]))
    else $error("selected byte was not stored");

  a_write_not_dropped: assert property (push_valid |-> fifo_push_ready)
    else $error("write word arrived with the buffer full");

  a_cmd_write_waits: assert property (cmd_write |=> wr_wait_a_q)
    else $error("write command did not arm the first word");

  a_ddr1_latency_b0: assert property (half_edge && !pll_on && rd_pipe_q[LAT_DDR1_B0].vld
                                      |=> o_output_valid_flag && o_dq == $past(mem[0][b0_addr]))
    else $error("first read word missing at the short latency");

  a_second_word_data: assert property (half_edge && b1_stage && !b0_stage
                                       |=> o_dq == $past(mem[1][b1_addr]))
    else $error("second read word not taken from the second array");

  a_oe_idle_off: assert property (half_edge && !launch |=> !o_dq_oe)
    else $error("data drivers left on after the last read word");

  a_out_stands: assert property (!half_edge |=> $stable(o_dq) && $stable(o_output_valid_flag))
    else $error("read word changed between clock edges");

  // Main scenarios the bench reaches; c_buffer_full marks a full buffer, which the bench checks never happens.
  c_read_pll: cover property (cmd_read && pll_on);
  c_read_short: cover property (cmd_read && !pll_on);
  c_back_to_back_reads: cover property (cmd_read ##[1:40] cmd_read);
  c_write_burst: cover property (push_b0 ##[1:40] push_b1);
  c_buffer_full: cover property (!fifo_push_ready);

endmodule // ddr_burst_sram

/* File: test/sram_ctrl_model.sv */
// Behavioural memory controller that drives the pin side of the burst SRAM.
module sram_ctrl_model #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 18
) (
  // Clock and run control.
  input  wire logic             i_mclk,
  input  wire logic             i_run,
  // Pins towards the memory.
  output logic                  o_k,
  output logic                  o_k_n,
  output logic                  o_load_strobe_n,
  output logic                  o_rd_wr,
  output logic [ADDR_W-1:0]     o_addr,
  output logic [DATA_W/9-1:0]   o_byte_write_sel_n,
  output logic [DATA_W-1:0]     o_dq,
  output logic                  o_dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed
  {
    logic                vld;
    logic                rd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   w0;
    logic [DATA_W-1:0]   w1;
    logic [DATA_W/9-1:0] b0;
    logic [DATA_W/9-1:0] b1;
  } ctrl_cmd_t;

  ctrl_cmd_t cmd_q [$];
  ctrl_cmd_t sent = '0;
  ctrl_cmd_t data_cmd = '0;
  int        ph = 7;

  // Queue one command; the pin process sends at most one per input clock period.
  task automatic push(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0,
                      input logic [DATA_W-1:0] w1, input logic [DATA_W/9-1:0] b0,
                      input logic [DATA_W/9-1:0] b1);
    cmd_q.push_back(ctrl_cmd_t'{vld: 1'b1, rd: rd, addr: a, w0: w0, w1: w1, b0: b0, b1: b1});
  endtask

  initial
  begin
    o_k = 1'b0;
    o_k_n = 1'b1;
    o_load_strobe_n = 1'b1;
    o_rd_wr = 1'b1;
    o_addr = '0;
    o_byte_write_sel_n = '1;
    o_dq = '0;
    o_dq_oe = 1'b0;
  end

  // Eight mclk per input clock period; commands change half a period away from the k rise.
  always @(negedge i_mclk)
  begin
    if (!i_run)
    begin
      ph = 7;
      o_k = 1'b0;
      o_k_n = 1'b1;
    end
    else
    begin
      ph = (ph + 1) % 8;
      o_k = (ph < 4);
      o_k_n = !o_k;
      if (ph == 4)
      begin
        data_cmd = sent;
        sent = '0;
        o_load_strobe_n = 1'b1;
        if (cmd_q.size() > 0)
        begin
          sent = cmd_q.pop_front();
          o_load_strobe_n = 1'b0;
          o_rd_wr = sent.rd;
          o_addr = sent.addr;
        end
      end
      // Word 0 straddles the next k rise, word 1 the k_n rise after it.
      if (ph == 6 || ph == 2)
      begin
        if (data_cmd.vld && !data_cmd.rd)
        begin
          o_dq = (ph == 6) ? data_cmd.w0 : data_cmd.w1;
          o_byte_write_sel_n = (ph == 6) ? data_cmd.b0 : data_cmd.b1;
          o_dq_oe = 1'b1;
        end
        else
        begin
          // A released bus keeps no value, so show a changing pattern instead.
          o_dq = ~o_dq;
          o_byte_write_sel_n = '1;
          o_dq_oe = 1'b0;
        end
      end
    end
  end

endmodule // sram_ctrl_model

/* File: test/ddr_burst_sram_test.sv */
// Self-checking bench for the burst SRAM pin engine and its write buffer.
`define CHECK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
    end \
  end

module ddr_burst_sram_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr_sram_pkg::*;

  localparam int AW = 4;
  localparam int DW = DQ_W_X18;
  localparam int NB = DW / 9;

  logic          mclk = 1'b0;
  logic          reset_n = 1'b0;
  logic          run = 1'b0;
  logic          pll_disable_n = 1'b0;
  logic          k, k_n, load_n, rd_wr, ctrl_oe, dut_oe, valid, echo, echo_n, wr_ready;
  logic [AW-1:0] addr;
  logic [NB-1:0] bws_n;
  logic [DW-1:0] ctrl_dq, dut_dq, dq_wire;
  logic [DW-1:0] sh0 [16];
  logic [DW-1:0] sh1 [16];
  int            fail_count = 0;
  int            n_checks = 0;

  // Clock and the resolved level of the shared data bus.
  always #12.5 mclk = ~mclk;
  assign dq_wire = dut_oe ? dut_dq : ctrl_dq;

  ddr_burst_sram #(.DATA_W(DW), .ADDR_W(AW)) i_ddr_burst_sram (
    .i_mclk(mclk), .i_reset_n(reset_n), .i_k(k), .i_k_n(k_n), .i_load_strobe_n(load_n),
    .i_rd_wr(rd_wr), .i_addr(addr), .i_byte_write_sel_n(bws_n), .i_pll_disable_n(pll_disable_n),
    .i_dq(dq_wire), .o_dq(dut_dq), .o_dq_oe(dut_oe), .o_output_valid_flag(valid),
    .o_echo_clock_out(echo), .o_echo_clock_out_n(echo_n), .o_write_ready(wr_ready));

  sram_ctrl_model #(.ADDR_W(AW), .DATA_W(DW)) i_sram_ctrl_model (
    .i_mclk(mclk), .i_run(run), .o_k(k), .o_k_n(k_n), .o_load_strobe_n(load_n), .o_rd_wr(rd_wr),
    .o_addr(addr), .o_byte_write_sel_n(bws_n), .o_dq(ctrl_dq), .o_dq_oe(ctrl_oe));

  task automatic tick();
    @(negedge mclk);
    #1;
  endtask

  // Reset for 12 cycles, then let the pin pipeline settle before the input clocks start.
  task automatic do_reset(input logic pll);
    run = 1'b0;
    reset_n = 1'b0;
    pll_disable_n = pll;
    repeat (12) tick();
    reset_n = 1'b1;
    repeat (4) tick();
    run = 1'b1;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w0, input logic [DW-1:0] w1,
                    input logic [NB-1:0] b0, input logic [NB-1:0] b1);
    i_sram_ctrl_model.push(1'b0, a, w0, w1, b0, b1);
    for (int i = 0; i < DW; i++)
    begin
      if (!b0[i / 9])
        sh0[a][i] = w0[i];
      if (!b1[i / 9])
        sh1[a][i] = w1[i];
    end
  endtask

  // Reads nb bursts from consecutive addresses at consecutive k rises and checks every word.
  task automatic rd_check(input logic [AW-1:0] a, input int nb, input int lat);
    int            t;
    logic          e0;
    logic [DW-1:0] exp;
    for (int b = 0; b < nb; b++)
      i_sram_ctrl_model.push(1'b1, AW'(a + b), '0, '0, '1, '1);
    t = 0;
    while (!(i_sram_ctrl_model.ph == 0 && load_n === 1'b0) && t < 100)
    begin
      tick();
      t++;
    end
    t = 0;
    e0 = echo;
    while (valid !== 1'b1 && t < 60)
    begin
      e0 = echo;
      tick();
      t++;
    end
    `CHECK("read latency", 1'b1, (t >= lat - 1) && (t <= lat + 1))
    `CHECK("valid on echo edge", 1'b1, echo !== e0)
    for (int w = 0; w < 2 * nb; w++)
    begin
      repeat (2) tick();
      exp = w[0] ? sh1[AW'(a + w / 2)] : sh0[AW'(a + w / 2)];
      `CHECK("read word", exp, dut_dq)
      `CHECK("read drive", 1'b1, dut_oe)
      repeat (2) tick();
    end
    tick();
    `CHECK("drivers off", 1'b0, dut_oe)
    `CHECK("valid low", 1'b0, valid)
  endtask

  task automatic t_reset_state();
    do_reset(1'b0);
    `CHECK("idle oe", 1'b0, dut_oe)
    repeat (10) tick();
    `CHECK("echo pair", ~echo, echo_n)
    `CHECK("idle valid", 1'b0, valid)
    $display("test reset_state done");
  endtask

  task automatic t_write_read();
    for (int i = 0; i < 4; i++)
      wr(AW'(i), DW'(18'h155AA ^ i), DW'(18'h0AA55 + 7 * i), '0, '0);
    repeat (80) tick();
    `CHECK("write ready", 1'b1, wr_ready)
    rd_check(4'h0, 1, 12);
    rd_check(4'h3, 1, 12);
    $display("test write_read done");
  endtask

  task automatic t_back_to_back();
    rd_check(4'h1, 3, 12);
    $display("test back_to_back done");
  endtask

  task automatic t_byte_selects();
    for (int c = 0; c < 4; c++)
      wr(AW'(8 + c), 18'h3FFFF, 18'h3FFFF, '0, '0);
    repeat (80) tick();
    for (int c = 0; c < 4; c++)
      wr(AW'(8 + c), 18'h00000, 18'h00000, NB'(c), NB'(3 - c));
    repeat (80) tick();
    rd_check(4'h8, 4, 12);
    $display("test byte_selects done");
  endtask

  task automatic t_write_only();
    int seen;
    seen = 0;
    wr(4'hC, 18'h12345, 18'h2BCDE, '0, '0);
    repeat (60)
    begin
      tick();
      seen += (valid !== 1'b0 || dut_oe !== 1'b0);
    end
    `CHECK("no read on write", 0, seen)
    rd_check(4'hC, 1, 12);
    $display("test write_only done");
  endtask

  task automatic t_pll_on();
    do_reset(1'b1);
    wr(4'h5, 18'h0F0F0, 18'h30303, '0, '0);
    wr(4'h6, 18'h24924, 18'h1B6DB, '0, '0);
    repeat (80) tick();
    rd_check(4'h5, 2, 24);
    $display("test pll_on done");
  endtask

  // Write buffer seen through the pins: back-to-back bursts must neither fill it nor lose a word.
  task automatic t_fifo();
    int low;
    low = 0;
    for (int i = 0; i < 4; i++)
      wr(AW'(8 + i), DW'(18'h2A5A5 ^ i), DW'(18'h15A5A + i), NB'(i % 3), '0);
    repeat (80)
    begin
      tick();
      low += (wr_ready !== 1'b1);
    end
    `CHECK("buffer full cycles", 0, low)
    `CHECK("buffer ready", 1'b1, wr_ready)
    rd_check(4'h8, 4, 24);
    `CHECK("buffer idle valid", 1'b0, valid)
    $display("test fifo done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence; everything runs in well under 4000 mclk cycles.
  initial
  begin
    t_reset_state();
    t_write_read();
    t_back_to_back();
    t_byte_selects();
    t_write_only();
    t_pll_on();
    t_fifo();
    tally_and_finish();
  end

  // Watchdog cuts a hang short at five times the expected run length.
  initial
  begin
    #(20000 * 25);
    fail_count++;
    $display("unexpected watchdog: expected end of tests, seen timeout");
    tally_and_finish();
  end

endmodule // ddr_burst_sram_test
